// >>> hw/dcc_consts.svh
// register offsets, field positions, reset values and codes for the channel config block
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
// direct host addresses, channel a then channel b
`define DCC_ADDR_GAIN_A 8'h03
`define DCC_ADDR_GAIN_B 8'h15
`define DCC_ADDR_IRNG_A 8'h04
`define DCC_ADDR_IRNG_B 8'h16
`define DCC_ADDR_CMOD_A 8'h05
`define DCC_ADDR_CMOD_B 8'h17
`define DCC_ADDR_FUNC_A 8'h06
`define DCC_ADDR_FUNC_B 8'h18
// power-management bus page and command codes
`define DCC_PM_PAGE   8'hFF
`define DCC_PM_GAIN_A 8'hD1
`define DCC_PM_GAIN_B 8'hDD
`define DCC_PM_IRNG_A 8'hD2
`define DCC_PM_IRNG_B 8'hDE
`define DCC_PM_CMOD_A 8'hD3
`define DCC_PM_CMOD_B 8'hDF
`define DCC_PM_FUNC_A 8'hD4
`define DCC_PM_FUNC_B 8'hE0
// reset value and writable-bit masks
`define DCC_RESET_VAL 16'h0000
`define DCC_MASK_GAIN 16'h1C1F
`define DCC_MASK_IRNG 16'h1E00
`define DCC_MASK_CMOD 16'h0C00
`define DCC_MASK_FUNC 16'hFFFF
// field positions
`define DCC_GAIN_LSB  10
`define DCC_CMP_EN    0
`define DCC_CMP_FLIP  1
`define DCC_CMP_DIV   2
`define DCC_CMP_ROUTE 3
`define DCC_CMP_DRAIN 4
`define DCC_IRNG_LSB  9
`define DCC_KIND_LSB  10
`define DCC_CLR_BIT   15
`define DCC_SYNC_BIT  14
`define DCC_BRD_BIT   13
// clear levels and validity limits
`define DCC_ZERO_SCALE  12'h000
`define DCC_MID_SCALE   12'h800
`define DCC_GAIN_MAX    3'h5
`define DCC_SPAN_PREFIX 2'h2
`endif

// >>> hw/dcc_pin_drv.sv
// comparator result conditioning and output pin driver for one channel
`timescale 1ns/10ps
module dcc_pin_drv (
  input  wire logic clk,                      // system clock
  input  wire logic reset,                    // synchronous, active high
  input  wire logic comparator_function_on,   // channel runs as comparator
  input  wire logic comparator_pin_route,     // result goes to the pin
  input  wire logic comparator_drain_style,   // 1 selects open-drain
  input  wire logic comparator_polarity_flip, // 1 inverts the result
  input  wire logic cmp_result,               // synchronised raw comparator result
  output logic      cmp_out,                  // conditioned result for internal use
  output logic      channel_output_pin_o,     // pin level when driven
  output logic      channel_output_pin_oe,    // high while the pin is driven
  output logic      pin_open_drain            // pin currently in open-drain style
);
  logic res;          // result after polarity
  logic pin_active;   // comparator owns the pin
  logic od;           // open-drain in force

  // combinational conditioning
  always_comb begin
    res        = cmp_result ^ comparator_polarity_flip;      // [R5]
    pin_active = comparator_function_on & comparator_pin_route; // [R3]
    // open-drain only counts while comparator and pin route are both on
    od         = comparator_drain_style & pin_active;        // [R2]
  end

  // internal result, zero while comparator mode is off
  always_ff @(posedge clk) begin
    if (reset) begin
      cmp_out <= 1'b0;
    end else begin
      cmp_out <= comparator_function_on & res; // [R6] [R3]
    end
  end

  // pin drive: push-pull drives both levels, open-drain only pulls low
  always_ff @(posedge clk) begin
    if (reset) begin
      channel_output_pin_o  <= 1'b0;
      channel_output_pin_oe <= 1'b0;
      pin_open_drain        <= 1'b0;
    end else begin
      channel_output_pin_o  <= pin_active & ~od & res;      // [R2]
      channel_output_pin_oe <= pin_active & (~od | ~res);   // [R2] [R3]
      pin_open_drain        <= od;
    end
  end
endmodule // dcc_pin_drv

// >>> hw/dcc_pkg.sv
// types shared by the channel config block
package dcc_pkg;
  // register slot inside one channel
  typedef enum logic [1:0] {
    DCC_REG_GAIN = 2'h0,
    DCC_REG_IRNG = 2'h1,
    DCC_REG_CMOD = 2'h2,
    DCC_REG_FUNC = 2'h3
  } dcc_reg_t;
  // comparator function kinds
  typedef enum logic [1:0] {
    DCC_KIND_PLAIN  = 2'h0,
    DCC_KIND_HYST   = 2'h1,
    DCC_KIND_WINDOW = 2'h2
  } dcc_kind_t;
endpackage

// >>> hw/dcc_top.sv
// per-channel output, comparator and function configuration registers for two channels
`timescale 1ns/10ps
`include "dcc_consts.svh"

// Behaviour
// R1: gain code picks voltage scaling and reference
// R2: drain bit: push-pull, or open-drain in comparator-pin
// R3: route bit sends comparator result to pin
// R4: divider bit selects sense input impedance
// R5: polarity bit inverts the comparator result
// R6: enable bit makes channel a comparator
// R7: four-bit code selects bipolar current span
// R8: two-bit code selects plain, hysteresis, window
// R9: margin codes give thresholds or window bounds
// R10: registers per channel, reset to zero
// R11: mode and function registers at fixed addresses
// R12: same registers reachable via page FFh commands
// R13: gain bits 12-10, comparator bits 4-0
// R14: clear bit picks zero or mid scale
// R15: sync bit: immediate or load-triggered update
// R16: broadcast bit includes channel in broadcast writes
// R17: invalid codes stored, last valid kept
// R18: don't-care bits ignore writes, read zero
module dcc_top (
  input  wire logic               clk,                        // 250 MHz system clock
  input  wire logic               reset,                      // synchronous, active high
  // register port
  input  wire logic               reg_wr_en,                  // one-cycle write strobe
  input  wire logic               reg_rd_en,                  // one-cycle read strobe
  input  wire logic               reg_pm_sel,                 // 1: page/command addressing
  input  wire logic [7:0]         reg_page,                   // active bus page
  input  wire logic [7:0]         reg_addr,                   // address or command code
  input  wire logic [15:0]        reg_wdata,                  // write data
  output logic      [15:0]        reg_rdata,                  // read data
  output logic                    reg_rd_valid,               // read data valid pulse
  output logic                    reg_miss,                   // unmapped access pulse
  // data path events on this clock
  input  wire logic [1:0]         data_write,                 // per-channel data write pulse
  input  wire logic               broadcast_write,            // broadcast data write pulse
  input  wire logic               sw_load_trigger,            // software load pulse
  input  wire logic               clear_request,              // clear pulse, both channels
  input  wire logic               load_strobe_pin,            // asynchronous load pin
  // analog side
  input  wire logic [1:0]         cmp_raw,                    // asynchronous comparator outputs
  input  wire logic [1:0][11:0]   margin_high_code,           // margin-high per channel
  input  wire logic [1:0][11:0]   margin_low_code,            // margin-low per channel
  output logic      [1:0][2:0]    voltage_gain_select,        // last valid gain code
  output logic      [1:0][3:0]    current_span_select,        // last valid current span
  output logic      [1:0]         current_span_valid,         // a valid span was ever set
  output logic      [1:0][1:0]    comparator_function_kind,   // last valid comparator kind
  output logic      [1:0]         hysteresis_on,              // hysteresis kind active
  output logic      [1:0]         window_on,                  // window kind active
  output logic      [1:0][11:0]   threshold_upper,            // upper threshold or bound
  output logic      [1:0][11:0]   threshold_lower,            // lower threshold or bound
  output logic      [1:0]         sense_input_divider_select, // sense input through divider
  output logic      [1:0]         comparator_function_on,     // channel in comparator mode
  output logic      [1:0]         cmp_out,                    // conditioned comparator result
  output logic      [1:0]         channel_output_pin_o,       // output pin level
  output logic      [1:0]         channel_output_pin_oe,      // output pin enable
  output logic      [1:0]         pin_open_drain,             // pin in open-drain style
  output logic      [1:0][11:0]   clear_level_select,         // code applied on a clear
  output logic      [1:0]         clear_apply,                // clear pulse per channel
  output logic      [1:0]         dac_update,                 // output update pulse
  output logic      [1:0][12:0]   waveform_settings_field     // function generator settings
);

  // register storage, indexed by channel and slot
  logic [15:0] cfg_ff [2][4];
  // decoded access: {hit, channel, slot}
  logic [3:0]  dec;
  logic        hit;
  logic        dch;
  logic [1:0]  dslot;
  // synchronisers for pins
  logic [1:0]  cmp_s1_ff;
  logic [1:0]  cmp_s2_ff;
  logic        load_s1_ff;
  logic        load_s2_ff;
  logic        load_s3_ff;
  logic        load_fall;     // falling edge of the synchronised load pin
  // last valid analog settings
  logic [1:0][2:0] gain_ff;
  logic [1:0][3:0] span_ff;
  logic [1:0]      span_ok_ff;
  logic [1:0][1:0] kind_ff;
  // update and clear pulses
  logic [1:0]      update_ff;
  logic [1:0]      clear_ff;
  logic [1:0][11:0] clr_code_ff;
  logic [1:0][11:0] thr_hi_ff;
  logic [1:0][11:0] thr_lo_ff;

  // address decoder shared by reads and writes
  function automatic logic [3:0] dcc_decode(input logic pm, input logic [7:0] page,
                                            input logic [7:0] addr);
    logic [3:0] r;
    r = 4'h0;
    if (!pm) begin
      case (addr) // [R10] [R11]
        `DCC_ADDR_GAIN_A: r = {2'b10, dcc_pkg::DCC_REG_GAIN};
        `DCC_ADDR_GAIN_B: r = {2'b11, dcc_pkg::DCC_REG_GAIN};
        `DCC_ADDR_IRNG_A: r = {2'b10, dcc_pkg::DCC_REG_IRNG};
        `DCC_ADDR_IRNG_B: r = {2'b11, dcc_pkg::DCC_REG_IRNG};
        `DCC_ADDR_CMOD_A: r = {2'b10, dcc_pkg::DCC_REG_CMOD};
        `DCC_ADDR_CMOD_B: r = {2'b11, dcc_pkg::DCC_REG_CMOD};
        `DCC_ADDR_FUNC_A: r = {2'b10, dcc_pkg::DCC_REG_FUNC};
        `DCC_ADDR_FUNC_B: r = {2'b11, dcc_pkg::DCC_REG_FUNC};
        default:          r = 4'h0;
      endcase
    end else if (page == `DCC_PM_PAGE) begin
      case (addr) // [R12]
        `DCC_PM_GAIN_A: r = {2'b10, dcc_pkg::DCC_REG_GAIN};
        `DCC_PM_GAIN_B: r = {2'b11, dcc_pkg::DCC_REG_GAIN};
        `DCC_PM_IRNG_A: r = {2'b10, dcc_pkg::DCC_REG_IRNG};
        `DCC_PM_IRNG_B: r = {2'b11, dcc_pkg::DCC_REG_IRNG};
        `DCC_PM_CMOD_A: r = {2'b10, dcc_pkg::DCC_REG_CMOD};
        `DCC_PM_CMOD_B: r = {2'b11, dcc_pkg::DCC_REG_CMOD};
        `DCC_PM_FUNC_A: r = {2'b10, dcc_pkg::DCC_REG_FUNC};
        `DCC_PM_FUNC_B: r = {2'b11, dcc_pkg::DCC_REG_FUNC};
        default:        r = 4'h0;
      endcase
    end
    return r;
  endfunction

  // writable bits of each slot; everything else is don't-care
  function automatic logic [15:0] dcc_mask(input logic [1:0] slot);
    logic [15:0] m;
    m = `DCC_MASK_FUNC;
    case (slot)
      dcc_pkg::DCC_REG_GAIN: m = `DCC_MASK_GAIN; // [R13]
      dcc_pkg::DCC_REG_IRNG: m = `DCC_MASK_IRNG;
      dcc_pkg::DCC_REG_CMOD: m = `DCC_MASK_CMOD;
      default:               m = `DCC_MASK_FUNC;
    endcase
    return m;
  endfunction

  // decode the current access
  always_comb begin
    dec   = dcc_decode(reg_pm_sel, reg_page, reg_addr);
    hit   = dec[3];
    dch   = dec[2];
    dslot = dec[1:0];
  end

  // register writes; masked bits are stored as zero so they read back zero
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < 4; s++) begin
          cfg_ff[c][s] <= `DCC_RESET_VAL; // [R10]
        end
      end
    end else if (reg_wr_en && hit) begin
      // invalid codes are stored as written, the analog side filters them
      cfg_ff[dch][dslot] <= reg_wdata & dcc_mask(dslot); // [R18] [R17]
    end
  end

  // read port: data one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata    <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= hit ? cfg_ff[dch][dslot] : 16'h0000; // [R18]
      end
    end
  end

  // unmapped access flag, one pulse per missed strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_miss <= 1'b0;
    end else begin
      reg_miss <= (reg_wr_en | reg_rd_en) & ~hit;
    end
  end

  // two-stage synchronisers for the comparator pins, three stages for the load pin; stage one feeds only stage two
  always_ff @(posedge clk) begin
    if (reset) begin
      cmp_s1_ff  <= 2'h0;
      cmp_s2_ff  <= 2'h0;
      load_s1_ff <= 1'b1;
      load_s2_ff <= 1'b1;
      load_s3_ff <= 1'b1;
    end else begin
      cmp_s1_ff  <= cmp_raw;
      cmp_s2_ff  <= cmp_s1_ff;
      load_s1_ff <= load_strobe_pin;
      load_s2_ff <= load_s1_ff;
      load_s3_ff <= load_s2_ff;
    end
  end

  // load pin falling edge, seen on settled stages only
  always_comb begin
    load_fall = load_s3_ff & ~load_s2_ff;
  end

  // last valid analog settings; an invalid code leaves the old one in force
  always_ff @(posedge clk) begin
    if (reset) begin
      gain_ff    <= '0;
      span_ff    <= '0;
      span_ok_ff <= 2'h0;
      kind_ff    <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        // gain codes above 101 are invalid
        if (cfg_ff[c][dcc_pkg::DCC_REG_GAIN][`DCC_GAIN_LSB +: 3] <= `DCC_GAIN_MAX) begin
          gain_ff[c] <= cfg_ff[c][dcc_pkg::DCC_REG_GAIN][`DCC_GAIN_LSB +: 3]; // [R1] [R17]
        end
        // spans are 1000 through 1011 only
        if (cfg_ff[c][dcc_pkg::DCC_REG_IRNG][`DCC_IRNG_LSB + 2 +: 2] == `DCC_SPAN_PREFIX) begin
          span_ff[c]    <= cfg_ff[c][dcc_pkg::DCC_REG_IRNG][`DCC_IRNG_LSB +: 4]; // [R7] [R17]
          span_ok_ff[c] <= 1'b1;
        end
        // kind 11 is invalid
        if (cfg_ff[c][dcc_pkg::DCC_REG_CMOD][`DCC_KIND_LSB +: 2] != 2'h3) begin
          kind_ff[c] <= cfg_ff[c][dcc_pkg::DCC_REG_CMOD][`DCC_KIND_LSB +: 2]; // [R8] [R17]
        end
      end
    end
  end

  // thresholds follow the margin codes only in hysteresis or window kinds
  always_ff @(posedge clk) begin
    if (reset) begin
      thr_hi_ff <= '0;
      thr_lo_ff <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        case (kind_ff[c])
          dcc_pkg::DCC_KIND_HYST, dcc_pkg::DCC_KIND_WINDOW: begin
            thr_hi_ff[c] <= margin_high_code[c]; // [R9]
            thr_lo_ff[c] <= margin_low_code[c];  // [R9]
          end
          default: begin
            // plain comparator has no second threshold
            thr_hi_ff[c] <= 12'h000;
            thr_lo_ff[c] <= 12'h000;
          end
        endcase
      end
    end
  end

  // output updates: immediate on a write, or held for the load trigger
  always_ff @(posedge clk) begin
    if (reset) begin
      update_ff <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cfg_ff[c][dcc_pkg::DCC_REG_FUNC][`DCC_SYNC_BIT]) begin
          // the held value is applied by pin edge or software trigger
          update_ff[c] <= load_fall | sw_load_trigger; // [R15]
        end else begin
          update_ff[c] <= data_write[c] |
                          (broadcast_write & cfg_ff[c][dcc_pkg::DCC_REG_FUNC][`DCC_BRD_BIT]);
          // [R15] [R16]
        end
      end
    end
  end

  // clear level and clear pulse per channel
  always_ff @(posedge clk) begin
    if (reset) begin
      clr_code_ff <= '0;
      clear_ff    <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        clr_code_ff[c] <= cfg_ff[c][dcc_pkg::DCC_REG_FUNC][`DCC_CLR_BIT] ?
                          `DCC_MID_SCALE : `DCC_ZERO_SCALE; // [R14]
        clear_ff[c]    <= clear_request;
      end
    end
  end

  // per-channel comparator pin stages
  for (genvar g = 0; g < 2; g++) begin : g_pin
    dcc_pin_drv u_pin (
      .clk                      (clk),
      .reset                    (reset),
      .comparator_function_on   (cfg_ff[g][dcc_pkg::DCC_REG_GAIN][`DCC_CMP_EN]),    // [R6]
      .comparator_pin_route     (cfg_ff[g][dcc_pkg::DCC_REG_GAIN][`DCC_CMP_ROUTE]), // [R3]
      .comparator_drain_style   (cfg_ff[g][dcc_pkg::DCC_REG_GAIN][`DCC_CMP_DRAIN]), // [R2]
      .comparator_polarity_flip (cfg_ff[g][dcc_pkg::DCC_REG_GAIN][`DCC_CMP_FLIP]),  // [R5]
      .cmp_result               (cmp_s2_ff[g]),
      .cmp_out                  (cmp_out[g]),
      .channel_output_pin_o     (channel_output_pin_o[g]),
      .channel_output_pin_oe    (channel_output_pin_oe[g]),
      .pin_open_drain           (pin_open_drain[g])
    );
  end

  // configuration outputs from the stored bits, the last-valid and threshold registers, and the clear and update pulses
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // the host must have powered down current output first; not checked here
      comparator_function_on[c]     = cfg_ff[c][dcc_pkg::DCC_REG_GAIN][`DCC_CMP_EN]; // [R6]
      sense_input_divider_select[c] = cfg_ff[c][dcc_pkg::DCC_REG_GAIN][`DCC_CMP_DIV]; // [R4]
      waveform_settings_field[c]    = cfg_ff[c][dcc_pkg::DCC_REG_FUNC][12:0];
      voltage_gain_select[c]        = gain_ff[c];
      current_span_select[c]        = span_ff[c];
      current_span_valid[c]         = span_ok_ff[c];
      comparator_function_kind[c]   = kind_ff[c];
      hysteresis_on[c]  = comparator_function_on[c] & (kind_ff[c] == dcc_pkg::DCC_KIND_HYST);
      window_on[c]      = comparator_function_on[c] & (kind_ff[c] == dcc_pkg::DCC_KIND_WINDOW);
      threshold_upper[c]    = thr_hi_ff[c];
      threshold_lower[c]    = thr_lo_ff[c];
      clear_level_select[c] = clr_code_ff[c];
      clear_apply[c]        = clear_ff[c];
      dac_update[c]         = update_ff[c];
    end
  end

endmodule // dcc_top

// >>> verif/dcc_host_model.sv
// host model driving the register port of the channel config block
`timescale 1ns/10ps
module dcc_host_model (
  input  wire logic        clk,          // system clock
  output logic             reg_wr_en,    // write strobe
  output logic             reg_rd_en,    // read strobe
  output logic             reg_pm_sel,   // page mode
  output logic [7:0]       reg_page,     // active page
  output logic [7:0]       reg_addr,     // address
  output logic [15:0]      reg_wdata,    // write data
  input  wire logic [15:0] reg_rdata,    // read data
  input  wire logic        reg_miss      // unmapped pulse
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_pm_sel = 1'b0;
    reg_page = 8'hFF;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // one access: strobe held for exactly one edge, answer taken just after that same edge
  task automatic access(input logic wr, pm, input logic [7:0] pg, a, input logic [15:0] d,
                        output logic [15:0] q, output logic miss);
    @(posedge clk);
    #1;
    reg_wr_en = wr;
    reg_rd_en = !wr;
    reg_pm_sel = pm;
    reg_page = pg;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    q = reg_rdata;
    miss = reg_miss;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    // released data shows its inverse
    reg_wdata = ~d;
  endtask
endmodule // dcc_host_model

// >>> verif/dcc_top_bench.sv
// self-checking bench for the channel config block
`timescale 1ns/10ps
`include "dcc_consts.svh"
module dcc_top_bench;
  logic clk = 1'b0, reset = 1'b1, bw = 1'b0, swl = 1'b0, clr = 1'b0, ld_pin = 1'b1;
  logic [1:0] dw = 2'h0, raw = 2'h0;
  logic [1:0][11:0] mh = {12'h000, 12'hABC}, ml = {12'h000, 12'h123};
  logic wr_en, rd_en, pm, rd_valid, miss;
  logic [7:0] page, addr;
  logic [15:0] wdata, rdata;
  logic [1:0][2:0] gain;
  logic [1:0][3:0] span;
  logic [1:0][1:0] kind;
  logic [1:0][11:0] thr_u, thr_l, clr_lvl;
  logic [1:0][12:0] wave;
  logic [1:0] span_ok, hyst, win, div, en, cmpo, pin_o, pin_oe, od, clr_ap, upd;
  int err_count = 0, tests_run = 0;
  always #2 clk = ~clk;
  dcc_host_model u_dcc_host_model (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_pm_sel(pm), .reg_page(page), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_miss(miss));
  dcc_top u_dcc_top (.clk(clk), .reset(reset), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_pm_sel(pm), .reg_page(page), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rd_valid(rd_valid), .reg_miss(miss), .data_write(dw),
    .broadcast_write(bw), .sw_load_trigger(swl), .clear_request(clr),
    .load_strobe_pin(ld_pin), .cmp_raw(raw), .margin_high_code(mh), .margin_low_code(ml),
    .voltage_gain_select(gain), .current_span_select(span), .current_span_valid(span_ok),
    .comparator_function_kind(kind), .hysteresis_on(hyst), .window_on(win),
    .threshold_upper(thr_u), .threshold_lower(thr_l), .sense_input_divider_select(div),
    .comparator_function_on(en), .cmp_out(cmpo), .channel_output_pin_o(pin_o),
    .channel_output_pin_oe(pin_oe), .pin_open_drain(od), .clear_level_select(clr_lvl),
    .clear_apply(clr_ap), .dac_update(upd), .waveform_settings_field(wave));
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic p, input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic m;
    u_dcc_host_model.access(1'b1, p, 8'hFF, a, d, q, m);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_regs();
    logic [15:0] mk[4] = '{`DCC_MASK_GAIN, `DCC_MASK_IRNG, `DCC_MASK_CMOD, `DCC_MASK_FUNC};
    logic [7:0] da, pc;
    logic [15:0] q;
    logic m;
    for (int i = 0; i < 8; i++) begin
      da = 8'((i < 4 ? `DCC_ADDR_GAIN_A : `DCC_ADDR_GAIN_B) + i % 4);
      pc = 8'((i < 4 ? `DCC_PM_GAIN_A : `DCC_PM_GAIN_B) + i % 4);
      u_dcc_host_model.access(1'b0, 1'b0, 8'hFF, da, 16'h0000, q, m);
      chk("reset value", 16'h0000, q);
      wr(1'b1, pc, 16'hFFFF);
      u_dcc_host_model.access(1'b0, 1'b0, 8'hFF, da, 16'h0000, q, m);
      chk("masked readback", mk[i % 4], q);
      wr(1'b0, da, 16'h0000);
      u_dcc_host_model.access(1'b0, 1'b1, 8'hFF, pc, 16'h0000, q, m);
      chk("command readback", 16'h0000, q);
    end
    u_dcc_host_model.access(1'b0, 1'b1, 8'h03, `DCC_PM_GAIN_A, 16'h0000, q, m);
    chk("foreign page", 16'h0001, {q[14:0], m});
    $display("register map done");
  endtask
  task automatic t_gain();
    logic [2:0] last = 3'h0;
    for (int c = 0; c < 8; c++) begin
      wr(1'b0, `DCC_ADDR_GAIN_A, 16'(c) << 10);
      settle(2);
      if (c <= 5) last = 3'(c);
      chk("gain code", 16'(last), 16'(gain[0]));
    end
    $display("gain done");
  endtask
  task automatic t_span();
    logic [3:0] last = 4'h0;
    for (int c = 0; c < 16; c++) begin
      wr(1'b0, `DCC_ADDR_IRNG_A, 16'(c) << 9);
      settle(2);
      if (c >= 8 && c <= 11) last = 4'(c);
      chk("span code", {15'(last), c >= 8}, {15'(span[0]), span_ok[0]});
    end
    $display("span done");
  endtask
  task automatic t_kind();
    logic [1:0] last = 2'h0;
    wr(1'b0, `DCC_ADDR_GAIN_A, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wr(1'b0, `DCC_ADDR_CMOD_A, 16'(k) << 10);
      settle(3);
      if (k < 3) last = 2'(k);
      chk("kind flags", {12'h0, last, last == 2'h2, last == 2'h1},
        {12'h0, kind[0], win[0], hyst[0]});
      chk("upper", |last ? 16'(mh[0]) : 16'h0000, 16'(thr_u[0]));
      chk("lower", |last ? 16'(ml[0]) : 16'h0000, 16'(thr_l[0]));
    end
    $display("kind done");
  endtask
  task automatic t_pin();
    logic [4:0] cf[7] = '{5'h01, 5'h09, 5'h0B, 5'h1B, 5'h19, 5'h18, 5'h04};
    logic [4:0] ex[7] = '{5'h01, 5'h07, 5'h04, 5'h0C, 5'h09, 5'h00, 5'h10};
    raw = 2'h1;
    for (int i = 0; i < 7; i++) begin
      wr(1'b0, `DCC_ADDR_GAIN_A, 16'(cf[i]));
      settle(5);
      chk("pin state", 16'(ex[i]),
        16'({div[0], od[0], pin_oe[0], pin_o[0], cmpo[0]}));
    end
    $display("pin done");
  endtask
  task automatic fire(input int w, input logic e);
    settle(1);
    {dw[0], bw, swl, ld_pin} = {w == 0, w == 1, w == 2, w != 3};
    settle(w == 3 ? 3 : 1);
    {dw[0], bw, swl, ld_pin} = 4'h1;
    chk("update", 16'(e), 16'(upd[0]));
  endtask
  task automatic t_func();
    wr(1'b0, `DCC_ADDR_FUNC_A, 16'h8ABC);
    settle(2);
    chk("mid scale", 16'h0800, 16'(clr_lvl[0]));
    chk("waveform", 16'h0ABC, 16'(wave[0]));
    clr = 1'b1;
    settle(1);
    clr = 1'b0;
    chk("clear", 16'h0003, 16'(clr_ap));
    fire(0, 1'b1);
    fire(1, 1'b0);
    wr(1'b0, `DCC_ADDR_FUNC_A, 16'h2000);
    settle(2);
    chk("zero scale", 16'h0000, 16'(clr_lvl[0]));
    fire(1, 1'b1);
    wr(1'b0, `DCC_ADDR_FUNC_A, 16'h4000);
    fire(0, 1'b0);
    fire(2, 1'b1);
    fire(3, 1'b1);
    $display("function done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    settle(2);
    reset = 1'b0;
    t_regs();
    t_gain();
    t_span();
    t_kind();
    t_pin();
    t_func();
    finish_test();
  end
  // watchdog: far beyond the whole sequence
  initial begin
    #40000;
    err_count++;
    finish_test();
  end
endmodule // dcc_top_bench

// >>> verif/dcc_top_checker.sv
// concurrent assertions on the ports of the channel config block
`timescale 1ns/10ps
module dcc_top_checker (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            reg_wr_en,
  input wire logic            reg_rd_en,
  input wire logic            reg_pm_sel,
  input wire logic [7:0]      reg_page,
  input wire logic            reg_rd_valid,
  input wire logic            reg_miss,
  input wire logic [1:0]      data_write,
  input wire logic            broadcast_write,
  input wire logic            sw_load_trigger,
  input wire logic            clear_request,
  input wire logic            load_strobe_pin,
  input wire logic [1:0]      comparator_function_on,
  input wire logic [1:0]      cmp_out,
  input wire logic [1:0]      channel_output_pin_o,
  input wire logic [1:0]      channel_output_pin_oe,
  input wire logic [1:0]      pin_open_drain,
  input wire logic [1:0]      window_on,
  input wire logic [1:0]      hysteresis_on,
  input wire logic [1:0][1:0] comparator_function_kind,
  input wire logic [1:0]      clear_apply,
  input wire logic [1:0]      dac_update
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  page_miss_a: assert property ((reg_wr_en || reg_rd_en) && reg_pm_sel &&
    reg_page != 8'hFF |=> reg_miss) else $error("foreign page not refused");
  clear_both_a: assert property (clear_apply == {2{$past(clear_request)}})
    else $error("clear pulse mismatch");
  // pin path: three sync flops, then the update flop
  update_cause_a: assert property (dac_update[0] |->
    $past(data_write[0] | broadcast_write | sw_load_trigger) ||
    ($past(load_strobe_pin, 4) && !$past(load_strobe_pin, 3)))
    else $error("update without cause");
  pin_idle_a: assert property (!comparator_function_on[0] ##1
    !comparator_function_on[0] |-> !channel_output_pin_oe[0]) else $error("idle pin driven");
  cmp_gate_a: assert property (!comparator_function_on[0] ##1
    !comparator_function_on[0] |-> !cmp_out[0]) else $error("result while disabled");
  drain_low_a: assert property (pin_open_drain[0] |-> !channel_output_pin_o[0])
    else $error("open drain drives high");
  window_kind_a: assert property (window_on[0] |-> comparator_function_kind[0] == 2'h2
    && comparator_function_on[0]) else $error("window flag wrong");
  hyst_kind_a: assert property (hysteresis_on[0] |-> comparator_function_kind[0] == 2'h1)
    else $error("hysteresis flag wrong");
  cover property (window_on[0]);
  cover property (pin_open_drain[0]);
  cover property (reg_miss);
endmodule // dcc_top_checker

bind dcc_top dcc_top_checker u_dcc_top_checker (.clk(clk), .reset(reset),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_pm_sel(reg_pm_sel),
  .reg_page(reg_page), .reg_rd_valid(reg_rd_valid), .reg_miss(reg_miss),
  .data_write(data_write), .broadcast_write(broadcast_write),
  .sw_load_trigger(sw_load_trigger), .clear_request(clear_request),
  .load_strobe_pin(load_strobe_pin), .comparator_function_on(comparator_function_on),
  .cmp_out(cmp_out), .channel_output_pin_o(channel_output_pin_o),
  .channel_output_pin_oe(channel_output_pin_oe), .pin_open_drain(pin_open_drain),
  .window_on(window_on), .hysteresis_on(hysteresis_on),
  .comparator_function_kind(comparator_function_kind), .clear_apply(clear_apply),
  .dac_update(dac_update));
